// >>> shared/brs_pkg.sv
package brs_pkg;
  // ==========================================================
  // reset sequencing timing
  localparam int unsigned MIN_RESET_CYC = 8;
  localparam int unsigned POST_RELEASE_CYC = 4;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] MIN_RESET_CNT = CNT_W'(MIN_RESET_CYC);
  localparam int unsigned REFRESH_DIV_DEF = 1000;
  localparam int unsigned REFRESH_W = 16;
  localparam int unsigned RATIO_W = 8;
  localparam int unsigned PCI_HALF_DEF = 4;
  // ==========================================================
  // pin group widths and reset values
  localparam int unsigned PROC_W = 16;
  localparam int unsigned PCI_W = 16;
  localparam int unsigned DP_W = 16;
  localparam int unsigned HI_W = 8;
  localparam int unsigned LO_W = 5;
  localparam logic [HI_W-1:0] HI_RESET = 8'hff;
  localparam logic [LO_W-1:0] LO_RESET = 5'h00;
  // positions inside the driven-high group
  localparam int unsigned HI_TRANSFER_ACK = 0;
  localparam int unsigned HI_TRANSFER_ERR_ACK = 1;
  localparam int unsigned HI_GRANT_ONE = 2;
  // positions inside the driven-low group
  localparam int unsigned LO_DATA_BUS_GRANT = 0;
  localparam int unsigned LO_SRAM_ADDR_STROBE = 1;
  localparam int unsigned LO_TAG_CLEAR = 2;
  localparam int unsigned LO_ROM_LOAD = 3;
  localparam int unsigned LO_WRITE_LATCH_OPEN = 4;
  // strap bit positions
  localparam int unsigned ST_ROM = 0;
  localparam int unsigned ST_RATIO = 1;
  // ==========================================================
  // synchroniser bit positions and idle value
  localparam int unsigned SY_RESET_N = 0;
  localparam int unsigned SY_STRAP = 1;
  localparam int unsigned SY_PCI_CLK = 3;
  localparam int unsigned SY_INT_REQ = 4;
  localparam int unsigned SY_XFER_N = 5;
  localparam int unsigned SY_W = 6;
  localparam logic [SY_W-1:0] SYNC_IDLE = 6'h20;
  // ==========================================================
  // state machines
  typedef enum logic [1:0] {
    BRS_HOLD = 2'b00,
    BRS_EXTEND = 2'b01,
    BRS_RUN = 2'b11
  } brs_state_t;
  typedef enum logic [1:0] {
    BRS_SYS_ASSERT = 2'b00,
    BRS_SYS_WAIT = 2'b01,
    BRS_SYS_READY = 2'b11
  } brs_sys_state_t;
endpackage : brs_pkg

// >>> shared/brs_link_if.sv
`timescale 1ns/1ps
interface brs_link_if;
  import brs_pkg::*;
  // ==========================================================
  // system side pins
  logic reset_n;
  logic pci_clk;
  logic int_req;
  logic xfer_start_n;
  logic scan_test_sel_n;
  logic io_test_select;
  logic [1:0] strap_pull;
  // ==========================================================
  // bridge side pins
  logic [PROC_W-1:0] proc_o;
  logic proc_oe;
  logic [PCI_W-1:0] pci_o;
  logic pci_oe;
  logic [DP_W-1:0] dp_o;
  logic dp_oe;
  logic [1:0] strap_o;
  logic strap_oe;
  logic [1:0] strap_i;
  logic [HI_W-1:0] hi_o;
  logic [LO_W-1:0] lo_o;
  logic int_cpu_n;
  logic cpu_parity_error_n;
  logic mem_error_n;
  // floating strap wire settles to its pull
  assign strap_i = strap_oe ? strap_o : strap_pull;
  modport bridge (
    input reset_n, pci_clk, int_req, xfer_start_n, scan_test_sel_n, io_test_select, strap_i,
    output proc_o, proc_oe, pci_o, pci_oe, dp_o, dp_oe, strap_o, strap_oe, hi_o, lo_o,
    output int_cpu_n, cpu_parity_error_n, mem_error_n
  );
  modport system (
    output reset_n, pci_clk, int_req, xfer_start_n, scan_test_sel_n, io_test_select,
    output strap_pull,
    input proc_o, proc_oe, pci_o, pci_oe, dp_o, dp_oe, strap_i, hi_o, lo_o,
    input int_cpu_n, cpu_parity_error_n, mem_error_n
  );
endinterface : brs_link_if

// >>> core/brs_sync.sv
`timescale 1ns/1ps
module brs_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // ==========================================================
  // two stage synchroniser, first stage read only by the second
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule : brs_sync

// >>> core/brs_bridge_end.sv
// Behaviour
// - system holds reset at least eight clocks
// - both clocks run throughout reset
// - no PCI transfer before four clocks
// - no processor transfer before four clocks
// - reset edges may be asynchronous
// - outputs at reset state by second clock (pins here reach it on the third)
// - initialise state, measure clock ratio during reset
// - outputs keep reset values until bus activity
// - interrupt output follows inverted request in reset
// - bus, strap and datapath pins float
// - listed memory and control outputs driven high
// - grant, strobe, clear, load, latch driven low
// - error outputs undefined, ignored during reset
// - datapath initialised only through controller controls
// - test selects held at safe levels
// - straps float, latched at reset release
// - strap levels select ratio mode, ROM location
// - refresh counter runs from release onward
`timescale 1ns/1ps
module brs_bridge_end
  import brs_pkg::*;
#(
  parameter int unsigned REFRESH_DIV = REFRESH_DIV_DEF
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  brs_link_if.bridge link,
  input wire logic [PROC_W-1:0] core_proc_i,
  input wire logic core_proc_oe_i,
  input wire logic [PCI_W-1:0] core_pci_i,
  input wire logic core_pci_oe_i,
  input wire logic [DP_W-1:0] core_dp_i,
  input wire logic core_dp_oe_i,
  input wire logic [1:0] core_strap_i,
  input wire logic core_strap_oe_i,
  input wire logic [HI_W-1:0] core_hi_i,
  input wire logic [LO_W-1:0] core_lo_i,
  input wire logic core_irq_en_i,
  input wire logic core_parity_err_n_i,
  input wire logic core_mem_err_n_i,
  output logic in_reset_o,
  output logic bus_active_o,
  output logic [RATIO_W-1:0] clk_ratio_o,
  output logic rom_remote_o,
  output logic core_ratio_fast_o,
  output logic refresh_tick_o
);
  // ==========================================================
  // pin synchronisers
  logic [SY_W-1:0] pins_s;
  logic reset_act;
  logic pci_rise;
  logic pci_prev_reg;
  // every pin from the system except the two test selects passes two flops first
  brs_sync #(
    .W(SY_W),
    .RST_VAL(SYNC_IDLE)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i({link.xfer_start_n, link.int_req, link.pci_clk, link.strap_i, link.reset_n}),
    .q_o(pins_s)
  );
  // reset level seen after two flops; edges may fall anywhere
  assign reset_act = ~pins_s[SY_RESET_N];
  assign pci_rise = pins_s[SY_PCI_CLK] & ~pci_prev_reg;

  // ==========================================================
  // reset sequencer
  brs_state_t state_reg;
  brs_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic cnt_done;
  logic in_reset;
  logic release_evt;
  logic active_reg;
  logic drive;
  assign cnt_done = (cnt_reg == MIN_RESET_CNT);
  assign in_reset = reset_act | (state_reg != BRS_RUN);
  assign release_evt = (state_reg != BRS_RUN) & (state_next == BRS_RUN);
  // pins leave their reset state only once a transfer has been seen
  assign drive = ~in_reset & active_reg;

  // next state: a short pulse still runs the full initialisation
  always_comb begin
    state_next = state_reg;
    if (reset_act) begin
      state_next = BRS_HOLD;
    end else begin
      case (state_reg)
        BRS_HOLD: state_next = cnt_done ? BRS_RUN : BRS_EXTEND;
        BRS_EXTEND: state_next = cnt_done ? BRS_RUN : BRS_EXTEND;
        BRS_RUN: state_next = BRS_RUN;
        default: state_next = BRS_HOLD;
      endcase
    end
  end

  // state register; release is synchronous to the clock
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= BRS_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // minimum pulse counter, saturates at the minimum
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (state_reg == BRS_RUN) begin
      cnt_reg <= '0;
    end else if (!cnt_done) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // bus activity flag, cleared by any reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      active_reg <= 1'b0;
    end else if (in_reset) begin
      active_reg <= 1'b0;
    end else if (!pins_s[SY_XFER_N]) begin
      active_reg <= 1'b1;
    end
  end

  // ==========================================================
  // clock ratio measurement
  logic [RATIO_W-1:0] gap_reg;
  // pci clock is sampled as a level; ratio is sys cycles per pci period
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pci_prev_reg <= 1'b0;
      gap_reg <= '0;
      clk_ratio_o <= '0;
    end else begin
      pci_prev_reg <= pins_s[SY_PCI_CLK];
      if (pci_rise) begin
        gap_reg <= '0;
      end else if (gap_reg != '1) begin
        gap_reg <= gap_reg + RATIO_W'(1);
      end
      if (in_reset && pci_rise) begin
        clk_ratio_o <= gap_reg + RATIO_W'(1);
      end
    end
  end

  // ==========================================================
  // strap capture at release; pins float all through reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rom_remote_o <= 1'b0;
      core_ratio_fast_o <= 1'b0;
    end else if (release_evt) begin
      rom_remote_o <= pins_s[SY_STRAP+ST_ROM];
      core_ratio_fast_o <= pins_s[SY_STRAP+ST_RATIO];
    end
  end

  // ==========================================================
  // floating groups: processor, pci, datapath buses and straps
  // one flop after the synchroniser, so the third clock edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link.proc_o <= '0;
      link.proc_oe <= 1'b0;
      link.pci_o <= '0;
      link.pci_oe <= 1'b0;
      link.dp_o <= '0;
      link.dp_oe <= 1'b0;
      link.strap_o <= '0;
      link.strap_oe <= 1'b0;
    end else begin
      link.proc_o <= drive ? core_proc_i : '0;
      link.proc_oe <= drive & core_proc_oe_i;
      link.pci_o <= drive ? core_pci_i : '0;
      link.pci_oe <= drive & core_pci_oe_i;
      // datapath chip has no reset pin; its buses follow these enables
      link.dp_o <= drive ? core_dp_i : '0;
      link.dp_oe <= drive & core_dp_oe_i;
      link.strap_o <= drive ? core_strap_i : '0;
      link.strap_oe <= drive & core_strap_oe_i;
    end
  end

  // ==========================================================
  // driven groups: high controls and low controls
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link.hi_o <= HI_RESET;
      link.lo_o <= LO_RESET;
    end else begin
      link.hi_o <= drive ? core_hi_i : HI_RESET;
      link.lo_o <= drive ? core_lo_i : LO_RESET;
    end
  end

  // interrupt mirrors the request in reset; error pins carry no promise
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link.int_cpu_n <= 1'b1;
      link.cpu_parity_error_n <= 1'b1;
      link.mem_error_n <= 1'b1;
    end else begin
      if (in_reset) begin
        link.int_cpu_n <= ~pins_s[SY_INT_REQ];
      end else begin
        link.int_cpu_n <= ~(pins_s[SY_INT_REQ] & core_irq_en_i);
      end
      link.cpu_parity_error_n <= core_parity_err_n_i;
      link.mem_error_n <= core_mem_err_n_i;
    end
  end

  // ==========================================================
  // refresh interval counter, free running once released
  logic [REFRESH_W-1:0] refresh_cnt_reg;
  localparam logic [REFRESH_W-1:0] REFRESH_LAST = REFRESH_W'(REFRESH_DIV - 1);
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      refresh_cnt_reg <= '0;
      refresh_tick_o <= 1'b0;
    end else if (in_reset) begin
      refresh_cnt_reg <= '0;
      refresh_tick_o <= 1'b0;
    end else if (refresh_cnt_reg == REFRESH_LAST) begin
      refresh_cnt_reg <= '0;
      refresh_tick_o <= 1'b1;
    end else begin
      refresh_cnt_reg <= refresh_cnt_reg + REFRESH_W'(1);
      refresh_tick_o <= 1'b0;
    end
  end

  // ==========================================================
  // user side status
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      in_reset_o <= 1'b1;
      bus_active_o <= 1'b0;
    end else begin
      in_reset_o <= in_reset;
      bus_active_o <= drive;
    end
  end
endmodule : brs_bridge_end

// >>> core/brs_system_end.sv
`timescale 1ns/1ps
module brs_system_end
  import brs_pkg::*;
#(
  parameter int unsigned HOLD_CYC = MIN_RESET_CYC,
  parameter int unsigned PCI_HALF = PCI_HALF_DEF,
  parameter logic [1:0] STRAP_PULL = 2'h1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  brs_link_if.system link,
  input wire logic reset_req_i,
  input wire logic start_i,
  input wire logic irq_i,
  output logic ready_o,
  output logic start_taken_o,
  output logic parity_err_o,
  output logic mem_err_o,
  output logic int_seen_o
);
  // ==========================================================
  // reset pulse generator and post release guard
  localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);
  localparam logic [7:0] WAIT_LAST = 8'(POST_RELEASE_CYC - 1);
  brs_sys_state_t state_reg;
  brs_sys_state_t state_next;
  logic [7:0] cnt_reg;
  logic start_ok;
  assign start_ok = (state_reg == BRS_SYS_READY) & start_i;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BRS_SYS_ASSERT: if (cnt_reg == HOLD_LAST) state_next = BRS_SYS_WAIT;
      BRS_SYS_WAIT: if (cnt_reg == WAIT_LAST) state_next = BRS_SYS_READY;
      BRS_SYS_READY: state_next = BRS_SYS_READY;
      default: state_next = BRS_SYS_ASSERT;
    endcase
    if (reset_req_i) begin
      state_next = BRS_SYS_ASSERT;
    end
  end

  // counter restarts on each state change
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= BRS_SYS_ASSERT;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg || reset_req_i) ? 8'h00 : cnt_reg + 8'h01;
    end
  end

  // reset pin low for exactly the assert state
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link.reset_n <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      link.reset_n <= (state_next != BRS_SYS_ASSERT);
      ready_o <= (state_next == BRS_SYS_READY);
    end
  end

  // ==========================================================
  // pci clock divider, never stopped so it runs through reset
  logic [7:0] div_reg;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_reg <= '0;
      link.pci_clk <= 1'b0;
    end else if (div_reg == 8'(PCI_HALF - 1)) begin
      div_reg <= '0;
      link.pci_clk <= ~link.pci_clk;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ==========================================================
  // transfer starts and static pins
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link.xfer_start_n <= 1'b1;
      start_taken_o <= 1'b0;
      link.int_req <= 1'b0;
      link.scan_test_sel_n <= 1'b1;
      link.io_test_select <= 1'b0;
      link.strap_pull <= STRAP_PULL;
    end else begin
      link.xfer_start_n <= ~start_ok;
      start_taken_o <= start_ok;
      link.int_req <= irq_i;
      link.scan_test_sel_n <= 1'b1;
      link.io_test_select <= 1'b0;
      link.strap_pull <= STRAP_PULL;
    end
  end

  // error pins mean nothing until the bridge is out of reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      parity_err_o <= 1'b0;
      mem_err_o <= 1'b0;
      int_seen_o <= 1'b0;
    end else begin
      parity_err_o <= ready_o & ~link.cpu_parity_error_n;
      mem_err_o <= ready_o & ~link.mem_error_n;
      int_seen_o <= ~link.int_cpu_n;
    end
  end
endmodule : brs_system_end

// >>> verification/brs_link_props.sv
`timescale 1ns/1ps
module brs_link_props
  import brs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic reset_n,
  input wire logic int_req,
  input wire logic xfer_start_n,
  input wire logic scan_test_sel_n,
  input wire logic io_test_select,
  input wire logic proc_oe,
  input wire logic pci_oe,
  input wire logic dp_oe,
  input wire logic strap_oe,
  input wire logic [HI_W-1:0] hi_o,
  input wire logic [LO_W-1:0] lo_o,
  input wire logic int_cpu_n
);
  // ==========================================================
  // pin reset entry and release
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // first low sample of the reset pin; a reset held from rst_i has no fall
  sequence entering;
    $fell(reset_n);
  endsequence
  sequence released;
    $rose(reset_n);
  endsequence
  // pins settle one edge later than the two-flop sampling
  AST_PINS_FLOAT: assert property (
    entering |-> ##3 (!proc_oe && !pci_oe && !dp_oe && !strap_oe))
    else $error("bus pins driven during reset");
  AST_HIGH_GROUP: assert property (
    entering |-> ##3 (hi_o == HI_RESET))
    else $error("driven-high group not high in reset");
  AST_LOW_GROUP: assert property (
    entering |-> ##3 (lo_o == LO_RESET))
    else $error("driven-low group not low in reset");
  AST_INT_LOW: assert property (
    (!reset_n && int_req) [*6] |-> !int_cpu_n)
    else $error("interrupt output not inverse of request");
  AST_INT_HIGH: assert property (
    (!reset_n && !int_req) [*6] |-> int_cpu_n)
    else $error("interrupt output not inverse of request");
  AST_MIN_PULSE: assert property (
    entering |-> (!reset_n) [*8])
    else $error("reset pulse shorter than eight cycles");
  AST_QUIET: assert property (
    released |-> xfer_start_n [*4])
    else $error("transfer started too soon after release");
  AST_HOLD_STATE: assert property (
    released |-> (hi_o == HI_RESET && lo_o == LO_RESET && !proc_oe && !pci_oe && !dp_oe) [*4])
    else $error("pins left reset state without activity");
  AST_TEST_SEL: assert property (
    scan_test_sel_n && !io_test_select)
    else $error("test selects not at safe levels");
endmodule : brs_link_props

// >>> verification/bridge_reset_sequencing_tb.sv
`timescale 1ns/1ps
module bridge_reset_sequencing_tb;
  import brs_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_req_i = 1'b0;
  logic start_i = 1'b0;
  logic irq_i = 1'b1;
  logic core_irq_en_i = 1'b0;
  // core values differ from every reset level but core_mem_err_n_i, so a missed reset shows
  logic [PROC_W-1:0] core_proc_i = 16'h1234;
  logic [PCI_W-1:0] core_pci_i = 16'h5678;
  logic [DP_W-1:0] core_dp_i = 16'h9abc;
  logic [HI_W-1:0] core_hi_i = 8'h5a;
  logic [LO_W-1:0] core_lo_i = 5'h15;
  logic [1:0] core_strap_i = 2'h2;
  logic core_oe = 1'b1;
  logic core_parity_err_n_i = 1'b0;
  logic core_mem_err_n_i = 1'b1;
  logic in_reset_o, bus_active_o, rom_remote_o, core_ratio_fast_o, refresh_tick_o;
  logic [RATIO_W-1:0] clk_ratio_o;
  logic ready_o, start_taken_o, parity_err_o, mem_err_o, int_seen_o;
  int failures = 0;
  int checks = 0;
  // free-running system clock
  always #2 clk_sys_i = ~clk_sys_i;
  // ==========================================================
  // the two ends and the wire checker
  brs_link_if link ();
  brs_bridge_end #(.REFRESH_DIV(8)) brs_bridge_end_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link),
    .core_proc_i(core_proc_i), .core_proc_oe_i(core_oe),
    .core_pci_i(core_pci_i), .core_pci_oe_i(core_oe),
    .core_dp_i(core_dp_i), .core_dp_oe_i(core_oe),
    .core_strap_i(core_strap_i), .core_strap_oe_i(core_oe),
    .core_hi_i(core_hi_i), .core_lo_i(core_lo_i), .core_irq_en_i(core_irq_en_i),
    .core_parity_err_n_i(core_parity_err_n_i), .core_mem_err_n_i(core_mem_err_n_i),
    .in_reset_o(in_reset_o), .bus_active_o(bus_active_o), .clk_ratio_o(clk_ratio_o),
    .rom_remote_o(rom_remote_o), .core_ratio_fast_o(core_ratio_fast_o),
    .refresh_tick_o(refresh_tick_o));
  brs_system_end #(.HOLD_CYC(8), .PCI_HALF(2), .STRAP_PULL(2'h1)) brs_system_end_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link),
    .reset_req_i(reset_req_i), .start_i(start_i), .irq_i(irq_i),
    .ready_o(ready_o), .start_taken_o(start_taken_o), .parity_err_o(parity_err_o),
    .mem_err_o(mem_err_o), .int_seen_o(int_seen_o));
  brs_link_props brs_link_props_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reset_n(link.reset_n), .int_req(link.int_req),
    .xfer_start_n(link.xfer_start_n), .scan_test_sel_n(link.scan_test_sel_n),
    .io_test_select(link.io_test_select), .proc_oe(link.proc_oe), .pci_oe(link.pci_oe),
    .dp_oe(link.dp_oe), .strap_oe(link.strap_oe), .hi_o(link.hi_o), .lo_o(link.lo_o),
    .int_cpu_n(link.int_cpu_n));
  // ==========================================================
  // shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // bounded wait, a missing ready shows up as a failed compare later
  task automatic wait_ready();
    for (int i = 0; i < 40 && ready_o !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    @(posedge clk_sys_i);
    #1;
  endtask : wait_ready
  task automatic chk_reset_pins();
    chk(16'(link.hi_o), 16'(HI_RESET));
    chk(16'(link.lo_o), 16'(LO_RESET));
    chk(16'({link.proc_oe, link.pci_oe, link.dp_oe, link.strap_oe}), 16'h0000);
  endtask : chk_reset_pins
  task end_sim();
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // scenarios
  task automatic t_power_up();
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk_reset_pins();
    chk(16'(link.int_cpu_n), 16'h0000);
    chk(16'(in_reset_o), 16'h0001);
    chk(16'(parity_err_o), 16'h0000);
    wait_ready();
    chk(16'(ready_o), 16'h0001);
    chk(16'(in_reset_o), 16'h0000);
    chk(16'(rom_remote_o), 16'h0001);
    chk(16'(core_ratio_fast_o), 16'h0000);
    chk(16'(clk_ratio_o), 16'h0004);
    chk_reset_pins();
    chk(16'(bus_active_o), 16'h0000);
  endtask : t_power_up
  task automatic t_activity();
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    #1;
    chk(16'(start_taken_o), 16'h0001);
    for (int i = 0; i < 12 && bus_active_o !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(16'(bus_active_o), 16'h0001);
    chk(link.proc_o, 16'h1234);
    chk(link.pci_o, 16'h5678);
    chk(link.dp_o, 16'h9abc);
    chk(16'(link.strap_i), 16'h0002);
    chk(16'(link.hi_o), 16'h005a);
    chk(16'(link.lo_o), 16'h0015);
    chk(16'(link.int_cpu_n), 16'h0001);
    chk(16'({parity_err_o, mem_err_o}), 16'h0002);
    // interrupt gate opens only outside reset; driven on the edge
    @(posedge clk_sys_i);
    core_irq_en_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    #1;
    chk(16'(link.int_cpu_n), 16'h0000);
    chk(16'(int_seen_o), 16'h0001);
  endtask : t_activity
  task automatic t_refresh();
    int n;
    n = 0;
    for (int i = 0; i < 20 && refresh_tick_o !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (refresh_tick_o !== 1'b1 && n < 20);
    chk(16'(n), 16'h0008);
  endtask : t_refresh
  // reset in mid-run, with a start attempted before ready
  task automatic t_mid_reset();
    @(posedge clk_sys_i);
    reset_req_i <= 1'b1;
    @(posedge clk_sys_i);
    reset_req_i <= 1'b0;
    start_i <= 1'b1;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    // request dropped early so it stays low for most of the pulse
    irq_i <= 1'b0;
    #1;
    chk(16'(start_taken_o), 16'h0000);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk_reset_pins();
    // four-flop path still shows the old request here
    chk(16'(link.int_cpu_n), 16'h0000);
    chk(16'(in_reset_o), 16'h0001);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(16'(link.int_cpu_n), 16'h0001);
    wait_ready();
    chk(16'(ready_o), 16'h0001);
    chk_reset_pins();
    chk(16'(link.dp_oe), 16'h0000);
    chk(16'(bus_active_o), 16'h0000);
  endtask : t_mid_reset
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_power_up();
    t_activity();
    t_refresh();
    t_mid_reset();
    end_sim();
  end
  // watchdog, the whole run needs well under a thousand cycles
  initial begin
    #40000;
    failures = failures + 1;
    end_sim();
  end
endmodule : bridge_reset_sequencing_tb
